/* logic/pmbus_cmd_pkg.sv */
// constants for the pmbus fault, protection and memory command block
package pmbus_cmd_pkg;
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;
  localparam logic [7:0] CMD_STORE_ALL = 8'h15;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
  localparam logic [7:0] CMD_CAPABILITY = 8'h19;
  localparam logic [7:0] PAGE_CH1 = 8'h00;
  localparam logic [7:0] PAGE_CH2 = 8'h01;
  localparam logic [7:0] PAGE_BOTH = 8'h0B;
  localparam logic [7:0] WP_ALL = 8'h80;
  localparam logic [7:0] WP_OP_PAGE = 8'h40;
  localparam logic [7:0] WP_OP_PAGE_CFG = 8'h20;
  localparam logic [7:0] WP_NONE = 8'h00;
  localparam logic [7:0] WP_FIELD_MASK = 8'hE0;
  localparam logic [7:0] CAP_VALUE = 8'hB0;
  localparam int CAP_PEC_BIT = 7;
  localparam int CAP_SPD_LSB = 5;
  localparam int CAP_ALERT_SUPPORT_BIT_BIT = 4;
  localparam logic [1:0] BUS_SPEED_400K = 2'h1;
  localparam int NCH = 2;
endpackage

/* logic/pmbus_cmd.sv */
// command interpreter: clear faults, write protection, nvm, capability
// Notes on behaviour
// - clear-faults code 03h clears all status bits of the selected pages
// - page 0 is channel 1, page 1 is channel 2, page 11 both
// - clearing faults releases the alert output in the same action when no unselected channel still holds a fault
// - clear-faults never restarts a channel latched off by a fault
// - a persisting fault sets its bit again and alerts again at once
// - protection restricts writes only; every command stays readable
// - byte 80h blocks all writes but write-protect and the 03h, 15h, 16h actions; needs bits 6,5 zero
// - byte 40h allows only write-protect, operation, page writes and the 03h, 15h, 16h actions
// - byte 20h adds on/off configuration to the allowed writes
// - invalid protection bits set communication summary and invalid-data
// - invalid protection value leaves protection register reading 00h
// - protection powers up unprotected unless another default was stored
// - restore updates only unprotected registers; invalid counts as none
// - reset reload and store-all ignore the protection setting
// - store-all 15h writes all storable settings into nonvolatile memory
// - store and restore allowed while running; device may be busy
// - memory programming error sets communication summary and other-fault
// - restore-all 16h copies stored data into unprotected backed registers; write-protect is copied only at 00h
// - capability 19h reads 10110000; writes ignored; low nibble zero
// - capability bit 7 reads 1: packet error checking supported
// - capability bits 6:5 read 01: 400 kHz maximum bus rate
// - capability bit 4 reads 1: alert output and response supported
`timescale 1ns/1ps
module pmbus_cmd
  import pmbus_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_data,
  output logic cmd_busy,
  output logic write_accepted,
  output logic [7:0] read_data,
  input wire logic [NCH-1:0] fault_in,
  output logic [NCH-1:0] fault_status,
  output logic [NCH-1:0] channel_off,
  output logic cml_summary,
  output logic cml_invalid_data,
  output logic cml_other_fault,
  output logic alert_n,
  output logic nvm_store_req,
  output logic nvm_load_req,
  output logic [7:0] nvm_wdata_wp,
  output logic [7:0] nvm_wdata_page,
  output logic [7:0] nvm_wdata_cfg,
  input wire logic nvm_done,
  input wire logic nvm_error,
  input wire logic [7:0] nvm_rdata_wp,
  input wire logic [7:0] nvm_rdata_page,
  input wire logic [7:0] nvm_rdata_cfg,
  output logic [7:0] page_value,
  output logic [7:0] on_off_cfg,
  output logic [7:0] operation_value
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_BOOT = 4'h1,
    ST_IDLE = 4'h2,
    ST_STORE = 4'h4,
    ST_LOAD = 4'h8
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic full_load;
    logic [7:0] wp;
    logic [7:0] page;
    logic [7:0] cfg;
    logic [7:0] op;
    logic [NCH-1:0] fault;
    logic [NCH-1:0] off;
    logic cml;
    logic ivd;
    logic oth;
    logic acc;
    logic [7:0] rd;
    logic [NCH-1:0] fsync1;
    logic [NCH-1:0] fsync2;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic wp_valid;
  logic allowed;
  logic [NCH-1:0] sel;
  logic [NCH-1:0] clr;

  // which backed registers a restore may touch under the live setting
  function automatic logic allowed_of(input logic [7:0] c);
    case (s_q.wp)
      WP_ALL: allowed_of = 1'b0;
      WP_OP_PAGE: allowed_of = (c == CMD_PAGE);
      WP_OP_PAGE_CFG: allowed_of = (c == CMD_PAGE) ||
        (c == CMD_ON_OFF_CONFIG);
      default: allowed_of = 1'b1;
    endcase
  endfunction

  // ----------------------------------------
  // protection decode
  // ----------------------------------------
  always_comb
  begin
    wp_valid = (s_q.wp == WP_ALL) || (s_q.wp == WP_OP_PAGE) ||
               (s_q.wp == WP_OP_PAGE_CFG);
    case (s_q.wp)
      WP_ALL: allowed = (cmd_code == CMD_WRITE_PROTECT);
      WP_OP_PAGE: allowed = (cmd_code == CMD_WRITE_PROTECT) ||
        (cmd_code == CMD_OPERATION) || (cmd_code == CMD_PAGE);
      WP_OP_PAGE_CFG: allowed = (cmd_code == CMD_WRITE_PROTECT) ||
        (cmd_code == CMD_OPERATION) || (cmd_code == CMD_PAGE) ||
        (cmd_code == CMD_ON_OFF_CONFIG);
      default: allowed = 1'b1;
    endcase
    case (s_q.page)
      PAGE_CH1: sel = 2'h1;
      PAGE_CH2: sel = 2'h2;
      PAGE_BOTH: sel = 2'h3;
      default: sel = 2'h0;
    endcase
  end

  assign clr = (s_q.phase == ST_IDLE && cmd_valid && cmd_write &&
                cmd_code == CMD_CLEAR_FAULTS) ? sel : '0;

  // ----------------------------------------
  // command engine
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.acc = 1'b0;
    // fault pins are asynchronous: two flops before any logic reads them;
    // nvm handshake lines share our clock and need none
    s_d.fsync1 = fault_in;
    s_d.fsync2 = s_q.fsync1;
    // persisting fault re-sets its bit; set wins over clear
    s_d.fault = (s_q.fault & ~clr) | s_q.fsync2;
    s_d.off = s_q.off | s_q.fsync2;
    case (s_q.phase)
      ST_BOOT:
      begin
        s_d.full_load = 1'b1;
        s_d.phase = ST_LOAD;
      end
      ST_IDLE:
      begin
        if (cmd_valid && cmd_write)
        begin
          if (cmd_code == CMD_CLEAR_FAULTS || cmd_code == CMD_STORE_ALL ||
              cmd_code == CMD_RESTORE_ALL)
          begin
            // actions, not register writes
            s_d.acc = 1'b1;
            if (cmd_code == CMD_CLEAR_FAULTS)
            begin
              s_d.cml = 1'b0;
              s_d.ivd = 1'b0;
              s_d.oth = 1'b0;
            end
            if (cmd_code == CMD_STORE_ALL)
              s_d.phase = ST_STORE;
            if (cmd_code == CMD_RESTORE_ALL)
            begin
              s_d.full_load = 1'b0;
              s_d.phase = ST_LOAD;
            end
          end
          else if (allowed)
          begin
            s_d.acc = (cmd_code != CMD_CAPABILITY);
            case (cmd_code)
              CMD_WRITE_PROTECT:
              begin
                if ((cmd_data & WP_FIELD_MASK) == WP_ALL ||
                    (cmd_data & WP_FIELD_MASK) == WP_OP_PAGE ||
                    (cmd_data & WP_FIELD_MASK) == WP_OP_PAGE_CFG ||
                    (cmd_data & WP_FIELD_MASK) == WP_NONE)
                  s_d.wp = cmd_data & WP_FIELD_MASK;
                else
                begin
                  s_d.wp = WP_NONE;
                  s_d.cml = 1'b1;
                  s_d.ivd = 1'b1;
                end
              end
              CMD_PAGE: s_d.page = cmd_data;
              CMD_OPERATION: s_d.op = cmd_data;
              CMD_ON_OFF_CONFIG: s_d.cfg = cmd_data;
              default: s_d.acc = 1'b0;
            endcase
          end
        end
        else if (cmd_valid)
        begin
          case (cmd_code)
            CMD_WRITE_PROTECT: s_d.rd = s_q.wp;
            CMD_PAGE: s_d.rd = s_q.page;
            CMD_OPERATION: s_d.rd = s_q.op;
            CMD_ON_OFF_CONFIG: s_d.rd = s_q.cfg;
            CMD_CAPABILITY: s_d.rd = CAP_VALUE;
            default: s_d.rd = WP_NONE;
          endcase
        end
      end
      ST_STORE:
      begin
        if (nvm_done)
        begin
          s_d.phase = ST_IDLE;
          if (nvm_error)
          begin
            s_d.cml = 1'b1;
            s_d.oth = 1'b1;
          end
        end
      end
      ST_LOAD:
      begin
        if (nvm_done)
        begin
          s_d.phase = ST_IDLE;
          // reset reload ignores protection; restore honours it
          if (s_q.full_load || !wp_valid || allowed_of(CMD_WRITE_PROTECT))
            s_d.wp = nvm_rdata_wp & WP_FIELD_MASK;
          if (s_q.full_load || !wp_valid || allowed_of(CMD_PAGE))
            s_d.page = nvm_rdata_page;
          if (s_q.full_load || !wp_valid || allowed_of(CMD_ON_OFF_CONFIG))
            s_d.cfg = nvm_rdata_cfg;
        end
      end
      default: s_d.phase = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.phase <= ST_BOOT;
      s_q.full_load <= 1'b1;
      s_q.wp <= WP_NONE;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // busy while memory runs: commands are dropped then
  assign cmd_busy = (s_q.phase != ST_IDLE);
  assign write_accepted = s_q.acc;
  assign read_data = s_q.rd;
  assign fault_status = s_q.fault;
  assign channel_off = s_q.off;
  assign cml_summary = s_q.cml;
  assign cml_invalid_data = s_q.ivd;
  assign cml_other_fault = s_q.oth;
  assign alert_n = !((|s_q.fault) || s_q.cml);
  assign nvm_store_req = (s_q.phase == ST_STORE);
  assign nvm_load_req = (s_q.phase == ST_LOAD);
  assign nvm_wdata_wp = s_q.wp;
  assign nvm_wdata_page = s_q.page;
  assign nvm_wdata_cfg = s_q.cfg;
  assign page_value = s_q.page;
  assign on_off_cfg = s_q.cfg;
  assign operation_value = s_q.op;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  clear_release_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (clr == 2'h3 && s_q.fsync2 == '0 && cmd_code == CMD_CLEAR_FAULTS)
    |=> alert_n)
    else $error("alert not released by clear");
  no_restart_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (|channel_off)
    |=> (channel_off & $past(channel_off)) == $past(channel_off))
    else $error("channel restarted");
  refault_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (|s_q.fsync2) |=> (|fault_status) && !alert_n)
    else $error("persisting fault lost");
  wp_invalid_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_q.phase == ST_IDLE && cmd_valid && cmd_write && allowed &&
     cmd_code == CMD_WRITE_PROTECT && !$onehot0(cmd_data[7:5]))
    |=> s_q.wp == WP_NONE && cml_summary && cml_invalid_data)
    else $error("invalid protection not flagged");
  wp_block_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_q.phase == ST_IDLE && s_q.wp == WP_ALL && cmd_valid && cmd_write &&
     cmd_code == CMD_PAGE) |=> $stable(page_value))
    else $error("blocked write took effect");
  cap_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_q.phase == ST_IDLE && cmd_valid && !cmd_write &&
     cmd_code == CMD_CAPABILITY) |=> read_data == CAP_VALUE)
    else $error("capability wrong");
  nvm_err_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (nvm_store_req && nvm_done && nvm_error)
    |=> cml_summary && cml_other_fault && !cmd_busy)
    else $error("nvm error not flagged");
  wp_legal_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $onehot0(s_q.wp[7:5]) && s_q.wp[4:0] == 5'h0)
    else $error("protection holds illegal value");
endmodule

/* verification/nvm_model.sv */
// behavioural nonvolatile memory behind the command block
`timescale 1ns/1ps
module nvm_model #(
  parameter int DLY = 3
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic nvm_store_req,
  input wire logic nvm_load_req,
  input wire logic [7:0] nvm_wdata_wp,
  input wire logic [7:0] nvm_wdata_page,
  input wire logic [7:0] nvm_wdata_cfg,
  input wire logic fail_store,
  output logic nvm_done,
  output logic nvm_error,
  output logic [7:0] nvm_rdata_wp,
  output logic [7:0] nvm_rdata_page,
  output logic [7:0] nvm_rdata_cfg
);
  logic [7:0] m_wp = 8'h00;
  logic [7:0] m_pg = 8'h01;
  logic [7:0] m_cf = 8'h16;
  int cnt;
  // ----------------------------------------
  // slow answer, the block stays busy
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 0;
      nvm_done <= 1'b0;
      nvm_error <= 1'b0;
    end
    else
    begin
      nvm_done <= 1'b0;
      nvm_error <= 1'b0;
      cnt <= 0;
      if ((nvm_store_req || nvm_load_req) && !nvm_done)
      begin
        cnt <= cnt + 1;
        if (cnt == DLY - 1)
        begin
          nvm_done <= 1'b1;
          nvm_error <= nvm_store_req && fail_store;
          if (nvm_store_req && !fail_store)
          begin
            m_wp <= nvm_wdata_wp;
            m_pg <= nvm_wdata_page;
            m_cf <= nvm_wdata_cfg;
          end
        end
      end
    end
  end
  // idle lines show garbage, not the last value
  assign nvm_rdata_wp = nvm_load_req ? m_wp : ~m_wp;
  assign nvm_rdata_page = nvm_load_req ? m_pg : ~m_pg;
  assign nvm_rdata_cfg = nvm_load_req ? m_cf : ~m_cf;
endmodule

/* verification/tb.sv */
// self-checking testbench for the pmbus command block
`timescale 1ns/1ps
module tb
  import pmbus_cmd_pkg::*;
;
  logic sys_clk, rst_b, cmd_valid, cmd_write, cmd_busy;
  logic write_accepted, cml_summary, cml_invalid_data;
  logic cml_other_fault, alert_n, nvm_store_req, nvm_load_req;
  logic nvm_done, nvm_error, fail_store;
  logic [7:0] cmd_code, cmd_data, read_data, nvm_wdata_wp;
  logic [7:0] nvm_wdata_page, nvm_wdata_cfg, nvm_rdata_wp;
  logic [7:0] nvm_rdata_page, nvm_rdata_cfg, page_value;
  logic [7:0] on_off_cfg, operation_value;
  logic [NCH-1:0] fault_in, fault_status, channel_off, off_seen;
  int num_errors, samples_checked;
  pmbus_cmd uut (.sys_clk, .rst_b, .cmd_valid, .cmd_write, .cmd_code,
    .cmd_data, .cmd_busy, .write_accepted, .read_data, .fault_in,
    .fault_status, .channel_off, .cml_summary, .cml_invalid_data,
    .cml_other_fault, .alert_n, .nvm_store_req, .nvm_load_req,
    .nvm_wdata_wp, .nvm_wdata_page, .nvm_wdata_cfg, .nvm_done,
    .nvm_error, .nvm_rdata_wp, .nvm_rdata_page, .nvm_rdata_cfg,
    .page_value, .on_off_cfg, .operation_value);
  nvm_model nvm (.sys_clk, .rst_b, .nvm_store_req, .nvm_load_req,
    .nvm_wdata_wp, .nvm_wdata_page, .nvm_wdata_cfg, .fail_store,
    .nvm_done, .nvm_error, .nvm_rdata_wp, .nvm_rdata_page,
    .nvm_rdata_cfg);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one command, answer sampled after the edge that registers it
  task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_data = d;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic e);
    cmd(1'b1, c, d);
    chk(write_accepted, e);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    cmd(1'b0, c, 8'h00);
    chk(read_data, e);
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (cmd_busy !== 1'b0)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 50)
      begin
        num_errors++;
        $display("mismatch at %0t: busy never drops", $time);
        tally_and_finish;
      end
    end
  endtask
  task automatic settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_boot;
    idle;
    chk(page_value, 8'h01);
    chk(on_off_cfg, 8'h16);
    rd(CMD_WRITE_PROTECT, WP_NONE);
    rd(CMD_CAPABILITY, CAP_VALUE);
    chk(read_data[CAP_PEC_BIT], 1'b1);
    chk(read_data[CAP_SPD_LSB +: 2], BUS_SPEED_400K);
    chk(read_data[CAP_ALERT_SUPPORT_BIT_BIT], 1'b1);
    chk(read_data & 8'h0F, 8'h00);
    wr(CMD_CAPABILITY, 8'h00, 1'b0);
    rd(CMD_CAPABILITY, CAP_VALUE);
  endtask
  task automatic t_protect;
    wr(CMD_WRITE_PROTECT, WP_ALL, 1'b1);
    wr(CMD_PAGE, PAGE_CH1, 1'b0);
    chk(page_value, 8'h01);
    rd(CMD_WRITE_PROTECT, WP_ALL);
    rd(CMD_PAGE, 8'h01);
    wr(CMD_WRITE_PROTECT, WP_OP_PAGE, 1'b1);
    wr(CMD_PAGE, PAGE_CH1, 1'b1);
    wr(CMD_ON_OFF_CONFIG, 8'h12, 1'b0);
    wr(CMD_OPERATION, 8'h80, 1'b1);
    chk(operation_value, 8'h80);
    wr(CMD_WRITE_PROTECT, WP_OP_PAGE_CFG, 1'b1);
    wr(CMD_ON_OFF_CONFIG, 8'h12, 1'b1);
    chk(on_off_cfg, 8'h12);
    rd(CMD_ON_OFF_CONFIG, 8'h12);
    rd(CMD_OPERATION, 8'h80);
    cmd(1'b1, CMD_WRITE_PROTECT, 8'hC0);
    chk(cml_summary, 1'b1);
    chk(cml_invalid_data, 1'b1);
    rd(CMD_WRITE_PROTECT, WP_NONE);
  endtask
  task automatic t_nvm;
    wr(CMD_STORE_ALL, 8'h00, 1'b1);
    chk(nvm_store_req, 1'b1);
    chk(cmd_busy, 1'b1);
    idle;
    chk(nvm_wdata_page, PAGE_CH1);
    wr(CMD_PAGE, PAGE_CH2, 1'b1);
    wr(CMD_ON_OFF_CONFIG, 8'h06, 1'b1);
    wr(CMD_WRITE_PROTECT, WP_OP_PAGE, 1'b1);
    wr(CMD_RESTORE_ALL, 8'h00, 1'b1);
    idle;
    chk(page_value, PAGE_CH1);
    chk(on_off_cfg, 8'h06);
    wr(CMD_WRITE_PROTECT, WP_NONE, 1'b1);
    wr(CMD_PAGE, PAGE_CH2, 1'b1);
    wr(CMD_WRITE_PROTECT, WP_ALL, 1'b1);
    wr(CMD_RESTORE_ALL, 8'h00, 1'b1);
    idle;
    chk(page_value, PAGE_CH2);
    rd(CMD_WRITE_PROTECT, WP_ALL);
    wr(CMD_WRITE_PROTECT, WP_OP_PAGE_CFG, 1'b1);
    wr(CMD_RESTORE_ALL, 8'h00, 1'b1);
    idle;
    chk(page_value, PAGE_CH1);
    chk(on_off_cfg, 8'h12);
    rd(CMD_WRITE_PROTECT, WP_OP_PAGE_CFG);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk(cml_summary, 1'b0);
    chk(cml_invalid_data, 1'b0);
    fail_store = 1'b1;
    wr(CMD_STORE_ALL, 8'h00, 1'b1);
    idle;
    fail_store = 1'b0;
    chk(cml_other_fault, 1'b1);
    chk(cml_summary, 1'b1);
  endtask
  task automatic t_fault;
    wr(CMD_WRITE_PROTECT, WP_NONE, 1'b1);
    wr(CMD_PAGE, PAGE_BOTH, 1'b1);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk(cml_summary, 1'b0);
    chk(alert_n, 1'b1);
    fault_in = 2'h1;
    settle;
    chk(fault_status, 2'h1);
    chk(alert_n, 1'b0);
    off_seen = channel_off;
    wr(CMD_PAGE, PAGE_CH1, 1'b1);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk(fault_status, 2'h1);
    chk(alert_n, 1'b0);
    fault_in = 2'h0;
    settle;
    wr(CMD_PAGE, PAGE_CH2, 1'b1);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk(fault_status, 2'h1);
    chk(alert_n, 1'b0);
    wr(CMD_PAGE, PAGE_CH1, 1'b1);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk(fault_status, 2'h0);
    chk(alert_n, 1'b1);
    chk(channel_off, off_seen);
  endtask
  // stored settings must come back as the power-up defaults
  task automatic t_reload;
    wr(CMD_PAGE, PAGE_CH2, 1'b1);
    wr(CMD_WRITE_PROTECT, WP_OP_PAGE, 1'b1);
    wr(CMD_STORE_ALL, 8'h00, 1'b1);
    chk(cmd_busy, 1'b1);
    idle;
    wr(CMD_PAGE, PAGE_CH1, 1'b1);
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    chk(cmd_busy, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(nvm_load_req, 1'b1);
    idle;
    chk(page_value, PAGE_CH2);
    chk(on_off_cfg, 8'h12);
    rd(CMD_WRITE_PROTECT, WP_OP_PAGE);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    num_errors = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_data = 8'h00;
    fault_in = 2'h0;
    fail_store = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    t_boot;
    t_protect;
    t_nvm;
    t_fault;
    t_reload;
    tally_and_finish;
  end
endmodule
